// ===== tpsr_defs.svh
// Register offsets, field positions, reset values and counts for the test pattern block
`ifndef TPSR_DEFS_SVH
`define TPSR_DEFS_SVH

// Register offsets on the serial configuration port
`define TPSR_ADDR_W 13
`define TPSR_ADDR_LINK_STATUS 13'h000a
`define TPSR_ADDR_TEST_CTRL 13'h000d
`define TPSR_ADDR_GEN_OUT 13'h000e

// Reset values
`define TPSR_RST_LINK_STATUS 8'h00
`define TPSR_RST_TEST_CTRL 8'h00
`define TPSR_RST_GEN_OUT 4'h0

// Link lock status fields
`define TPSR_BIT_SYNTH_LOCK 7
`define TPSR_BIT_LINK_READY 0

// Test pattern control fields
`define TPSR_BIT_USER_SINGLE 7
`define TPSR_BIT_RST_LONG 5
`define TPSR_BIT_RST_SHORT 4
`define TPSR_MODE_MSB 3
`define TPSR_MODE_LSB 0
`define TPSR_TEST_CTRL_WMASK 8'hbf

// General output field
`define TPSR_GEN_OUT_W 4

// Serial frame: read flag, two length bits, address, then one data byte
`define TPSR_SPI_INSTR_BITS 5'h10
`define TPSR_SPI_FRAME_BITS 5'h18
`define TPSR_SPI_READ_BIT 15

// Pseudorandom generators: length and feedback tap
`define TPSR_LONG_PSEUDORANDOM_SEQUENCE_LEN 23
`define TPSR_LONG_PSEUDORANDOM_SEQUENCE_TAP 18
`define TPSR_SHORT_PSEUDORANDOM_SEQUENCE_LEN 9
`define TPSR_SHORT_PSEUDORANDOM_SEQUENCE_TAP 5

// Number of user patterns in a cycle
`define TPSR_USER_PATTERNS 4

`endif

// ===== tpsr_pkg.sv
// Types shared by the test pattern block
package tpsr_pkg;

   // Output test modes
   typedef enum logic [3:0] {
      TPSR_MODE_OFF = 4'h0,
      TPSR_MODE_MID = 4'h1,
      TPSR_MODE_POS_FS = 4'h2,
      TPSR_MODE_NEG_FS = 4'h3,
      TPSR_MODE_CHECKER = 4'h4,
      TPSR_MODE_LONG_PSEUDORANDOM_SEQUENCE = 4'h5,
      TPSR_MODE_SHORT_PSEUDORANDOM_SEQUENCE = 4'h6,
      TPSR_MODE_WORD_TOGGLE = 4'h7,
      TPSR_MODE_USER = 4'h8,
      TPSR_MODE_RAMP = 4'hf
   } tpsr_mode_e;

endpackage

// ===== tpsr_lfsr.sv
// Pseudorandom word generator, several shifts per sample step
`timescale 1ns/100ps
module tpsr_lfsr #(
   parameter int LEN = 23,
   parameter int TAP = 18,
   parameter int WIDTH = 14
) (
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic hold_i,
   input wire logic step_i,
   output logic [WIDTH-1:0] word_o
);

   // Elaboration check on the polynomial shape
   initial begin
      if (LEN < 2 || TAP < 1 || TAP >= LEN || WIDTH < 1) begin
         $error("tpsr_lfsr: bad LEN, TAP or WIDTH");
      end
   end

   logic [LEN-1:0] state;
   logic [LEN-1:0] next_state;

   // Next WIDTH bits from the current state form the word on offer
   always_comb begin
      logic [LEN-1:0] s;
      logic fb;
      s = state;
      fb = 1'b0;
      word_o = '0;
      for (int i = WIDTH - 1; i >= 0; i--) begin
         fb = s[LEN-1] ^ s[TAP-1];
         s = {s[LEN-2:0], fb};
         word_o[i] = fb;
      end
      next_state = state;
      if (hold_i) begin
         next_state = '1;
         word_o = '0;
      end else if (step_i) begin
         next_state = s;
      end
   end

   // Generator state; the word is taken at the edge that steps it
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state <= '1;
      end else begin
         state <= next_state;
      end
   end

endmodule

// ===== tpsr_pattern_gen.sv
// Per-channel test data selector that replaces converter samples
`timescale 1ns/100ps
`include "tpsr_defs.svh"
module tpsr_pattern_gen #(
   parameter int DATA_W = 14
) (
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic sample_valid_i,
   input wire logic [3:0] mode_i,
   input wire logic user_single_i,
   input wire logic [DATA_W-1:0] adc_data_i,
   input wire logic [`TPSR_USER_PATTERNS*DATA_W-1:0] user_pattern_i,
   input wire logic [DATA_W-1:0] long_pseudorandom_sequence_i,
   input wire logic [DATA_W-1:0] short_pseudorandom_sequence_i,
   output logic [DATA_W-1:0] data_o
);

   initial begin
      if (DATA_W < 2) begin
         $error("tpsr_pattern_gen: DATA_W too small");
      end
   end

   logic toggle;
   logic next_toggle;
   logic [DATA_W-1:0] ramp;
   logic [DATA_W-1:0] next_ramp;
   logic [2:0] user_idx;
   logic [2:0] next_user_idx;
   logic [3:0] mode_q;
   logic [DATA_W-1:0] next_data;

   // Select the next output word for each mode
   always_comb begin
      logic [DATA_W-1:0] checker_word;
      checker_word = '0;
      for (int i = 0; i < DATA_W; i++) begin
         checker_word[i] = (i % 2 == 1) ^ toggle;
      end
      next_data = data_o;
      next_toggle = toggle;
      next_ramp = ramp;
      next_user_idx = user_idx;
      // Restart the user sequence on entry to user mode
      if (mode_i != mode_q) begin
         next_user_idx = 3'h0;
      end
      if (sample_valid_i) begin
         next_toggle = ~toggle;
         unique case (tpsr_pkg::tpsr_mode_e'(mode_i))
            tpsr_pkg::TPSR_MODE_OFF: next_data = adc_data_i;
            tpsr_pkg::TPSR_MODE_MID: next_data = '0;
            tpsr_pkg::TPSR_MODE_POS_FS: next_data = {1'b0, {(DATA_W-1){1'b1}}};
            tpsr_pkg::TPSR_MODE_NEG_FS: next_data = {1'b1, {(DATA_W-1){1'b0}}};
            tpsr_pkg::TPSR_MODE_CHECKER: next_data = checker_word;
            tpsr_pkg::TPSR_MODE_LONG_PSEUDORANDOM_SEQUENCE: next_data = long_pseudorandom_sequence_i;
            tpsr_pkg::TPSR_MODE_SHORT_PSEUDORANDOM_SEQUENCE: next_data = short_pseudorandom_sequence_i;
            tpsr_pkg::TPSR_MODE_WORD_TOGGLE: next_data = toggle ? '0 : '1;
            tpsr_pkg::TPSR_MODE_USER: begin
               if (next_user_idx < 3'h4) begin
                  next_data = user_pattern_i[next_user_idx[1:0]*DATA_W +: DATA_W];
                  next_user_idx = (next_user_idx == 3'h3 && !user_single_i) ? 3'h0 : next_user_idx + 3'h1;
               end else begin
                  next_data = '0;
               end
            end
            tpsr_pkg::TPSR_MODE_RAMP: begin
               next_data = ramp;
               next_ramp = ramp + {{(DATA_W-1){1'b0}}, 1'b1};
            end
            default: next_data = adc_data_i; // Reserved codes pass data
         endcase
      end
   end

   // Output word and sequence state
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         data_o <= '0;
         toggle <= 1'b0;
         ramp <= '0;
         user_idx <= 3'h0;
         mode_q <= 4'h0;
      end else begin
         data_o <= next_data;
         toggle <= next_toggle;
         ramp <= next_ramp;
         user_idx <= next_user_idx;
         mode_q <= mode_i;
      end
   end

endmodule

// ===== tpsr_top.sv
// Test pattern, link status and general output registers behind the serial port
//
// Operation
// - Status bit 7 shows synthesizer lock; register is read-only.
// - Status bit 0 is 1 only when link ready and locked; 0 after reset.
// - User mode bit 0 repeats patterns 1,2,3,4 continuously.
// - User mode bit 1 sends each pattern once, then zeros.
// - Mode 0000 normal, 0001 midscale, 0010 +full-scale, 0011 -full-scale.
// - Mode 0100 outputs checkerboard bits instead of samples.
// - Mode 0111 alternates all-ones and all-zeros words.
// - Mode 0101 outputs the long pseudorandom sequence.
// - Mode 0110 outputs the short pseudorandom sequence.
// - Mode 1000 user patterns, 1111 ramp; 1001 to 1110 reserved.
// - Control bit 5 holds the long generator in reset.
// - Control bit 4 holds the short generator in reset.
// - Selected test data replaces samples, set per channel.
// - General output register low four bits drive the four pins.
`timescale 1ns/100ps
`include "tpsr_defs.svh"
module tpsr_top #(
   parameter int NUM_CH = 8,
   parameter int DATA_W = 14
) (
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic spi_sclk_i,
   input wire logic spi_csb_n_i,
   input wire logic spi_sdio_i,
   output logic spi_sdio_o,
   output logic spi_sdio_oe_o,
   input wire logic synth_locked_i,
   input wire logic link_ready_i,
   input wire logic [NUM_CH-1:0] channel_select_i,
   input wire logic [`TPSR_USER_PATTERNS*DATA_W-1:0] user_pattern_i,
   input wire logic sample_valid_i,
   input wire logic [NUM_CH*DATA_W-1:0] adc_data_i,
   output logic [NUM_CH*DATA_W-1:0] out_data_o,
   output logic out_valid_o,
   output logic [`TPSR_GEN_OUT_W-1:0] gen_out_pins_o
);

   // Elaboration checks on parameters and shared constants
   initial begin
      // Channel count and word width
      if (NUM_CH < 1 || NUM_CH > 16) begin
         $error("tpsr_top: NUM_CH out of range");
      end
      if (DATA_W < 2) begin
         $error("tpsr_top: DATA_W too small");
      end
      // Pin field and user pattern count
      if (`TPSR_GEN_OUT_W < 1 || `TPSR_GEN_OUT_W > 8) begin
         $error("tpsr_top: output pin field does not fit its register");
      end
      if (`TPSR_USER_PATTERNS != 4) begin
         $error("tpsr_top: user sequence logic serves four patterns");
      end
      // Serial frame layout
      if (`TPSR_ADDR_W != 13) begin
         $error("tpsr_top: address field must be 13 bits");
      end
      if (`TPSR_SPI_INSTR_BITS != 16) begin
         $error("tpsr_top: instruction must be 16 bits");
      end
      if (`TPSR_SPI_FRAME_BITS != `TPSR_SPI_INSTR_BITS + 8) begin
         $error("tpsr_top: frame must carry one data byte");
      end
      if (`TPSR_SPI_READ_BIT != 15) begin
         $error("tpsr_top: read flag must lead the instruction");
      end
      // Field positions inside a byte and generator taps
      if (`TPSR_MODE_MSB - `TPSR_MODE_LSB != 3) begin
         $error("tpsr_top: mode field must be four bits");
      end
      if (`TPSR_BIT_SYNTH_LOCK > 7 || `TPSR_BIT_LINK_READY > 7) begin
         $error("tpsr_top: status bit outside the byte");
      end
      if (`TPSR_BIT_USER_SINGLE > 7 || `TPSR_BIT_RST_LONG > 7 || `TPSR_BIT_RST_SHORT > 7) begin
         $error("tpsr_top: control bit outside the byte");
      end
      if (`TPSR_LONG_PSEUDORANDOM_SEQUENCE_TAP >= `TPSR_LONG_PSEUDORANDOM_SEQUENCE_LEN || `TPSR_SHORT_PSEUDORANDOM_SEQUENCE_TAP >= `TPSR_SHORT_PSEUDORANDOM_SEQUENCE_LEN) begin
         $error("tpsr_top: generator tap beyond its length");
      end
   end

   // Serial port state
   logic sclk_q;
   logic [4:0] spi_cnt;
   logic [4:0] next_spi_cnt;
   logic [15:0] spi_shift;
   logic [15:0] next_spi_shift;
   logic spi_rd;
   logic next_spi_rd;
   logic [`TPSR_ADDR_W-1:0] spi_addr;
   logic [`TPSR_ADDR_W-1:0] next_spi_addr;
   logic [7:0] spi_out;
   logic [7:0] next_spi_out;
   logic next_sdio;
   logic next_sdio_oe;
   logic sclk_rise;
   logic sclk_fall;
   logic wr_en;
   logic [7:0] wr_data;

   // Register state
   logic [7:0] link_status;
   logic [7:0] next_link_status;
   logic [7:0] test_ctrl [NUM_CH];
   logic [7:0] next_test_ctrl [NUM_CH];
   logic [`TPSR_GEN_OUT_W-1:0] next_gen_out;
   logic [7:0] rd_data;
   logic [7:0] sel_ctrl;

   // Serial clock edges, seen against the previous sample
   assign sclk_rise = spi_sclk_i & ~sclk_q;
   assign sclk_fall = ~spi_sclk_i & sclk_q;

   // Frame decode: 16 instruction bits then one data byte
   // Instruction: read flag, two ignored length bits, 13-bit address
   // Rises past the 24th are ignored; a short frame writes nothing
   // Read bits leave on falls so the host takes them before each rise
   always_comb begin
      next_spi_cnt = spi_cnt;
      next_spi_shift = spi_shift;
      next_spi_rd = spi_rd;
      next_spi_addr = spi_addr;
      next_spi_out = spi_out;
      next_sdio = spi_sdio_o;
      next_sdio_oe = spi_sdio_oe_o;
      wr_en = 1'b0;
      wr_data = {spi_shift[6:0], spi_sdio_i};
      // Idle between frames: rewind and release the line
      if (spi_csb_n_i) begin
         next_spi_cnt = 5'h00;
         next_sdio_oe = 1'b0;
         next_spi_rd = 1'b0;
      end else if (sclk_rise) begin
         next_spi_shift = {spi_shift[14:0], spi_sdio_i};
         // Count rises up to the end of the frame
         if (spi_cnt < `TPSR_SPI_FRAME_BITS) begin
            next_spi_cnt = spi_cnt + 5'h01;
         end
         // Last instruction bit: latch direction and address
         if (spi_cnt == `TPSR_SPI_INSTR_BITS - 5'h01) begin
            next_spi_rd = spi_shift[`TPSR_SPI_READ_BIT-1];
            next_spi_addr = {spi_shift[11:0], spi_sdio_i};
         end
         // Last data bit of a write frame
         if (spi_cnt == `TPSR_SPI_FRAME_BITS - 5'h01 && !spi_rd) begin
            wr_en = 1'b1;
         end
      end else if (sclk_fall && spi_rd) begin
         // First fall after the instruction drives bit 7
         if (spi_cnt == `TPSR_SPI_INSTR_BITS) begin
            next_sdio = rd_data[7];
            next_spi_out = {rd_data[6:0], 1'b0};
            next_sdio_oe = 1'b1;
         end else if (spi_cnt > `TPSR_SPI_INSTR_BITS && spi_cnt < `TPSR_SPI_FRAME_BITS) begin
            next_sdio = spi_out[7];
            next_spi_out = {spi_out[6:0], 1'b0};
         end else begin
            // Past the last bit: let go of the line
            next_sdio_oe = 1'b0;
         end
      end
   end

   // Serial port registers
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sclk_q <= 1'b0;
         spi_cnt <= 5'h00;
         spi_shift <= 16'h0000;
         spi_rd <= 1'b0;
         spi_addr <= '0;
         spi_out <= 8'h00;
         spi_sdio_o <= 1'b0;
         spi_sdio_oe_o <= 1'b0;
      end else begin
         sclk_q <= spi_sclk_i;
         spi_cnt <= next_spi_cnt;
         spi_shift <= next_spi_shift;
         spi_rd <= next_spi_rd;
         spi_addr <= next_spi_addr;
         spi_out <= next_spi_out;
         spi_sdio_o <= next_sdio;
         spi_sdio_oe_o <= next_sdio_oe;
      end
   end

   // Read view of test control: lowest selected channel, else channel 0
   always_comb begin
      sel_ctrl = test_ctrl[0];
      // Walk down so the lowest selected channel wins
      for (int c = NUM_CH - 1; c >= 0; c--) begin
         if (channel_select_i[c]) begin
            sel_ctrl = test_ctrl[c];
         end
      end
   end

   // Read data mux; unmapped addresses read zero
   always_comb begin
      unique case (spi_addr)
         `TPSR_ADDR_LINK_STATUS: rd_data = link_status;
         `TPSR_ADDR_TEST_CTRL: rd_data = sel_ctrl;
         `TPSR_ADDR_GEN_OUT: rd_data = {{(8-`TPSR_GEN_OUT_W){1'b0}}, gen_out_pins_o};
         default: rd_data = 8'h00;
      endcase
   end

   // Status, control and output register updates
   always_comb begin
      next_link_status = `TPSR_RST_LINK_STATUS;
      next_link_status[`TPSR_BIT_SYNTH_LOCK] = synth_locked_i;
      next_link_status[`TPSR_BIT_LINK_READY] = synth_locked_i & link_ready_i;
      next_gen_out = gen_out_pins_o;
      // Control writes reach every selected channel
      for (int c = 0; c < NUM_CH; c++) begin
         next_test_ctrl[c] = test_ctrl[c];
         if (wr_en && spi_addr == `TPSR_ADDR_TEST_CTRL && channel_select_i[c]) begin
            next_test_ctrl[c] = wr_data & `TPSR_TEST_CTRL_WMASK;
         end
      end
      // Pins take the low bits of a write
      if (wr_en && spi_addr == `TPSR_ADDR_GEN_OUT) begin
         next_gen_out = wr_data[`TPSR_GEN_OUT_W-1:0];
      end
   end

   // Register bank; status writes are simply not decoded
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         link_status <= `TPSR_RST_LINK_STATUS;
         gen_out_pins_o <= `TPSR_RST_GEN_OUT;
         out_valid_o <= 1'b0;
         // Every channel starts in normal mode
         for (int c = 0; c < NUM_CH; c++) begin
            test_ctrl[c] <= `TPSR_RST_TEST_CTRL;
         end
      end else begin
         // Status follows the inputs one clock late
         link_status <= next_link_status;
         gen_out_pins_o <= next_gen_out;
         out_valid_o <= sample_valid_i;
         for (int c = 0; c < NUM_CH; c++) begin
            test_ctrl[c] <= next_test_ctrl[c];
         end
      end
   end

   // One pattern generator and two sequence generators per channel
   for (genvar g = 0; g < NUM_CH; g++) begin : gen_ch
      logic [DATA_W-1:0] long_pseudorandom_sequence_word;
      logic [DATA_W-1:0] short_pseudorandom_sequence_word;

      // Long sequence generator, held by its control bit
      tpsr_lfsr #(
         .LEN(`TPSR_LONG_PSEUDORANDOM_SEQUENCE_LEN),
         .TAP(`TPSR_LONG_PSEUDORANDOM_SEQUENCE_TAP),
         .WIDTH(DATA_W)
      ) u_long_pseudorandom_sequence (
         .ref_clk_i(ref_clk_i),
         .reset_n_i(reset_n_i),
         .hold_i(test_ctrl[g][`TPSR_BIT_RST_LONG]),
         .step_i(sample_valid_i),
         .word_o(long_pseudorandom_sequence_word)
      );

      // Short sequence generator, held by its control bit
      tpsr_lfsr #(
         .LEN(`TPSR_SHORT_PSEUDORANDOM_SEQUENCE_LEN),
         .TAP(`TPSR_SHORT_PSEUDORANDOM_SEQUENCE_TAP),
         .WIDTH(DATA_W)
      ) u_short_pseudorandom_sequence (
         .ref_clk_i(ref_clk_i),
         .reset_n_i(reset_n_i),
         .hold_i(test_ctrl[g][`TPSR_BIT_RST_SHORT]),
         .step_i(sample_valid_i),
         .word_o(short_pseudorandom_sequence_word)
      );

      // Mode decode and output word for this channel
      tpsr_pattern_gen #(
         .DATA_W(DATA_W)
      ) u_pattern (
         .ref_clk_i(ref_clk_i),
         .reset_n_i(reset_n_i),
         .sample_valid_i(sample_valid_i),
         .mode_i(test_ctrl[g][`TPSR_MODE_MSB:`TPSR_MODE_LSB]),
         .user_single_i(test_ctrl[g][`TPSR_BIT_USER_SINGLE]),
         .adc_data_i(adc_data_i[g*DATA_W +: DATA_W]),
         .user_pattern_i(user_pattern_i),
         .long_pseudorandom_sequence_i(long_pseudorandom_sequence_word),
         .short_pseudorandom_sequence_i(short_pseudorandom_sequence_word),
         .data_o(out_data_o[g*DATA_W +: DATA_W])
      );
   end

endmodule

// ===== tpsr_top_asserts.sv
// Port-level checker for the test pattern and status block
`timescale 1ns/100ps
`include "tpsr_defs.svh"
module tpsr_top_checker #(
   parameter int NUM_CH = 8,
   parameter int DATA_W = 14
) (
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic spi_sclk_i,
   input wire logic spi_csb_n_i,
   input wire logic sample_valid_i,
   input wire logic spi_sdio_o,
   input wire logic spi_sdio_oe_o,
   input wire logic [NUM_CH*DATA_W-1:0] out_data_o,
   input wire logic out_valid_o,
   input wire logic [`TPSR_GEN_OUT_W-1:0] gen_out_pins_o
);
   default clocking @(posedge ref_clk_i);
   endclocking
   default disable iff (!reset_n_i);

   // Output word timing against sample strobe
   property p_valid_follow;
      sample_valid_i |=> out_valid_o;
   endproperty
   a_valid_follow: assert property (p_valid_follow) else $error("no word after sample");
   property p_valid_cause;
      out_valid_o |-> $past(sample_valid_i);
   endproperty
   a_valid_cause: assert property (p_valid_cause) else $error("word without sample");
   property p_data_hold;
      !out_valid_o |-> $stable(out_data_o);
   endproperty
   a_data_hold: assert property (p_data_hold) else $error("word moved between samples");

   // Pins move only inside a frame
   property p_gen_hold;
      $past(spi_csb_n_i) |-> $stable(gen_out_pins_o);
   endproperty
   a_gen_hold: assert property (p_gen_hold) else $error("pins moved outside frame");

   // Read data driver follows select and clock falls
   property p_oe_needs_csb;
      spi_sdio_oe_o |-> !$past(spi_csb_n_i);
   endproperty
   a_oe_needs_csb: assert property (p_oe_needs_csb) else $error("sdio driven while idle");
   property p_oe_rise;
      $rose(spi_sdio_oe_o) |-> !$past(spi_sclk_i) && !spi_csb_n_i;
   endproperty
   a_oe_rise: assert property (p_oe_rise) else $error("sdio enable off clock fall");
   property p_sdio_shift;
      spi_sdio_oe_o && $changed(spi_sdio_o) |-> !$past(spi_sclk_i);
   endproperty
   a_sdio_shift: assert property (p_sdio_shift) else $error("sdio moved on clock high");
   property p_oe_fall;
      $fell(spi_sdio_oe_o) |-> !$past(spi_sclk_i) || $past(spi_csb_n_i);
   endproperty
   a_oe_fall: assert property (p_oe_fall) else $error("sdio released early");

   // Main scenarios reached
   c_pins: cover property ($changed(gen_out_pins_o));
   c_read: cover property ($rose(spi_sdio_oe_o));
   c_word: cover property (out_valid_o ##1 !out_valid_o);
endmodule

bind tpsr_top tpsr_top_checker #(.NUM_CH(NUM_CH), .DATA_W(DATA_W)) u_tpsr_chk (
   .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .spi_sclk_i(spi_sclk_i), .spi_csb_n_i(spi_csb_n_i),
   .sample_valid_i(sample_valid_i), .spi_sdio_o(spi_sdio_o), .spi_sdio_oe_o(spi_sdio_oe_o),
   .out_data_o(out_data_o), .out_valid_o(out_valid_o), .gen_out_pins_o(gen_out_pins_o));

// ===== tpsr_link_rx.sv
// Link receiver model that captures each output word
`timescale 1ns/100ps
module tpsr_link_rx #(
   parameter int W = 112
) (
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic valid_i,
   input wire logic [W-1:0] data_i,
   output logic [W-1:0] word_o
);
   // Capture the whole bus on each word strobe
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         word_o <= '0;
      end else if (valid_i) begin
         word_o <= data_i;
      end
   end
endmodule

// ===== test_pattern_status_regs_tb.sv
// Self-checking bench for the test pattern and status registers
`timescale 1ns/100ps
`include "tpsr_defs.svh"
module test_pattern_status_regs_tb;
   logic ref_clk_i = 0;
   logic reset_n_i = 0;
   logic sclk = 0, csb_n = 1, host_sdio = 1, sdio_o, sdio_oe, lock = 0, ready = 0, svalid = 0, out_valid;
   logic [111:0] adc_bus = '0, out_data, rx_word;
   logic [3:0] pins;
   logic [7:0] rd;
   logic [13:0] w0, w1;
   logic [13:0] fixed [0:3] = '{14'h0123, 14'h0000, 14'h1fff, 14'h2000};
   logic [13:0] up [0:3] = '{14'h0111, 14'h0222, 14'h0333, 14'h0444};
   int n_fail = 0, checks_done = 0;
   wire sdio_line = sdio_oe ? sdio_o : host_sdio;

   // Clock at 40 MHz
   always #12.5 ref_clk_i = ~ref_clk_i;

   tpsr_top DUT (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .spi_sclk_i(sclk), .spi_csb_n_i(csb_n),
      .spi_sdio_i(sdio_line), .spi_sdio_o(sdio_o), .spi_sdio_oe_o(sdio_oe), .synth_locked_i(lock),
      .link_ready_i(ready), .channel_select_i(8'h01), .user_pattern_i({up[3], up[2], up[1], up[0]}),
      .sample_valid_i(svalid), .adc_data_i(adc_bus), .out_data_o(out_data), .out_valid_o(out_valid),
      .gen_out_pins_o(pins));
   tpsr_link_rx #(.W(112)) rx (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .valid_i(out_valid),
      .data_i(out_data), .word_o(rx_word));

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask

   task automatic chk(input logic [13:0] got, input logic [13:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Expected pseudorandom word k after the all-ones seed, MSB first
   function automatic logic [13:0] pn(input int len, input int tap, input int k);
      logic [22:0] s;
      logic [13:0] w;
      s = '1;
      w = '0;
      for (int n = 0; n <= k; n++) begin
         for (int i = 13; i >= 0; i--) begin
            w[i] = s[len-1] ^ s[tap-1];
            s = {s[21:0], w[i]};
         end
      end
      return w;
   endfunction

   // One serial frame, clock idle low, read bits caught before each rise
   task automatic xfer(input logic r, input logic [12:0] a, input logic [7:0] d);
      logic [23:0] f;
      f = {r, 2'b00, a, d};
      csb_n <= 0;
      for (int i = 0; i < 24; i++) begin
         sclk <= 0;
         host_sdio <= f[23-i];
         cyc(4);
         if (i >= 16) rd[23-i] = sdio_line;
         sclk <= 1;
         cyc(4);
      end
      sclk <= 0;
      cyc(4);
      csb_n <= 1;
      host_sdio <= 1;
      cyc(4);
   endtask

   task automatic rreg(input logic [12:0] a, input logic [7:0] e);
      xfer(1'b1, a, 8'hff);
      chk({6'h00, rd}, {6'h00, e});
   endtask

   // One sample on all channels; only channel 0 sees test data
   task automatic smp(input logic [13:0] v, output logic [13:0] w);
      for (int g = 0; g < 8; g++) adc_bus[g*14 +: 14] <= v + 14'(g);
      svalid <= 1;
      cyc(1);
      svalid <= 0;
      cyc(2);
      w = rx_word[13:0];
      chk(rx_word[27:14], v + 14'h0001);
   endtask

   task automatic pair(input logic [7:0] c);
      xfer(1'b0, `TPSR_ADDR_TEST_CTRL, c);
      smp(14'h0123, w0);
      smp(14'h0123, w1);
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      cyc(16);
      reset_n_i <= 1;
      cyc(2);
      rreg(`TPSR_ADDR_LINK_STATUS, 8'h00);
      rreg(`TPSR_ADDR_TEST_CTRL, 8'h00);
      rreg(`TPSR_ADDR_GEN_OUT, 8'h00);
      rreg(13'h000b, 8'h00);
      $display("test reset values done");
      lock <= 1;
      rreg(`TPSR_ADDR_LINK_STATUS, 8'h80);
      ready <= 1;
      rreg(`TPSR_ADDR_LINK_STATUS, 8'h81);
      lock <= 0;
      rreg(`TPSR_ADDR_LINK_STATUS, 8'h00);
      lock <= 1;
      xfer(1'b0, `TPSR_ADDR_LINK_STATUS, 8'hff);
      rreg(`TPSR_ADDR_LINK_STATUS, 8'h81);
      $display("test status done");
      xfer(1'b0, `TPSR_ADDR_GEN_OUT, 8'ha5);
      chk({10'h000, pins}, 14'h0005);
      rreg(`TPSR_ADDR_GEN_OUT, 8'h05);
      $display("test pins done");
      for (int m = 0; m < 4; m++) begin
         xfer(1'b0, `TPSR_ADDR_TEST_CTRL, 8'(m));
         smp(14'h0123, w0);
         chk(w0, fixed[m]);
      end
      pair(8'h04);
      chk({1'b0, w0[13:1] ^ w0[12:0]}, 14'h1fff);
      chk(w1, ~w0);
      pair(8'h07);
      chk({1'b0, w0[13:1] ^ w0[12:0]}, 14'h0000);
      chk(w1, ~w0);
      pair(8'h0f);
      chk(w1, w0 + 14'h0001);
      $display("test fixed modes done");
      pair(8'h25);
      chk(w0 | w1, 14'h0000);
      pair(8'h05);
      chk(w0, pn(`TPSR_LONG_PSEUDORANDOM_SEQUENCE_LEN, `TPSR_LONG_PSEUDORANDOM_SEQUENCE_TAP, 0));
      chk(w1, pn(`TPSR_LONG_PSEUDORANDOM_SEQUENCE_LEN, `TPSR_LONG_PSEUDORANDOM_SEQUENCE_TAP, 1));
      pair(8'h16);
      chk(w0 | w1, 14'h0000);
      pair(8'h06);
      chk(w0, pn(`TPSR_SHORT_PSEUDORANDOM_SEQUENCE_LEN, `TPSR_SHORT_PSEUDORANDOM_SEQUENCE_TAP, 0));
      chk(w1, pn(`TPSR_SHORT_PSEUDORANDOM_SEQUENCE_LEN, `TPSR_SHORT_PSEUDORANDOM_SEQUENCE_TAP, 1));
      $display("test pseudorandom done");
      xfer(1'b0, `TPSR_ADDR_TEST_CTRL, 8'h08);
      for (int k = 0; k < 6; k++) begin
         smp(14'h0123, w0);
         chk(w0, up[k%4]);
      end
      xfer(1'b0, `TPSR_ADDR_TEST_CTRL, 8'h00);
      smp(14'h0321, w0);
      chk(w0, 14'h0321);
      xfer(1'b0, `TPSR_ADDR_TEST_CTRL, 8'hc8);
      rreg(`TPSR_ADDR_TEST_CTRL, 8'h88);
      for (int k = 0; k < 6; k++) begin
         smp(14'h0123, w0);
         chk(w0, k < 4 ? up[k] : 14'h0000);
      end
      $display("test user patterns done");
      tally_and_finish();
   end
endmodule
